// File: pg_consts.svh
`ifndef PG_CONSTS_SVH
`define PG_CONSTS_SVH
// timing figures in their own units
`define CLK_PERIOD_NS 100
`define UV_OV_FILTER_US 30
`define RELEASE_DELAY_US 120
`define HICCUP_DELAY_US 3500
`define SOFT_START_MIN_US 500
// cycle counts: filter is a least time (round up, plus one so it is strictly more)
`define FILTER_CYC ((`UV_OV_FILTER_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define RELEASE_CYC ((`RELEASE_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HICCUP_CYC ((`HICCUP_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SOFT_START_CYC ((`SOFT_START_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// current limit selection codes
`define ILIM_SEL_50MV 2'h0
`define ILIM_SEL_70MV 2'h1
`define ILIM_SEL_100MV 2'h2
// apb register map
`define REG_CTRL_ADDR 12'h000
`define REG_STATUS_ADDR 12'h004
`define CTRL_RESET_VAL 3'h0
// ctrl fields
`define CTRL_LATCH_BIT 0
`define CTRL_ILIM_LSB 1
`endif

// File: pg_pkg.sv
`default_nettype none
package pg_pkg;
  typedef enum logic [2:0] {ST_OFF, ST_SOFT, ST_RUN, ST_HICCUP, ST_LATCH} seq_state_t;
  typedef enum logic [1:0] {MODE_AUTO, MODE_FPWM, MODE_SYNC} op_mode_t;
endpackage
`default_nettype wire

// File: power_good_fault_supervisor.sv
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "pg_consts.svh"
// Functional notes
// RULE1: mode pin high selects forced pwm, low selects auto pwm/pfm.
// RULE2: external clock on mode pin locks switching and forces pwm.
// RULE3: external sync clock pulses stay at least 100 ns wide.
// RULE4: sync clock is 0.5 to 1.5 of set frequency, 250k-1M.
// RULE5: soft-start and synchronisation run together when started with clock.
// RULE6: duty extension drops sync; frequency may fall to one quarter.
// RULE7: low input sags frequency linearly to one quarter of set value.
// RULE8: power ok pulled low in shutdown, lockout, soft-start, uv, ov, faults.
// RULE9: power ok released when every pulling condition clears.
// RULE10: undervolt flagged after feedback low for more than 30 us.
// RULE11: after feedback above 93 percent, wait 120 us before power ok.
// RULE12: overcurrent, short or overvolt during undervolt enters hiccup or latch.
// RULE13: feedback overvolt halts switching.
// RULE14: overvolt flagged after feedback high for more than 30 us.
// RULE15: below 107 percent, power ok after 120 us, switching resumes.
// RULE16: output overvolt stops switching while present.
// RULE17: switch node short detected against 0.43 V drop comparator.
// RULE18: latch keeps output off until enable low or lockout.
// RULE19: hiccup stops switching and restarts after 3.5 ms, repeating.
// RULE20: current limit ends high-side pulse; threshold 50, 70 or 100 mV.
// RULE21: soft-start starts at enable rise, lasts at least 500 us.
// RULE22: comparators arrive synchronised; intervals counted on own clock.
module power_good_fault_supervisor
  import pg_pkg::*;
#(
  parameter int HICCUP_CYCLES = `HICCUP_CYC,
  parameter int SOFT_CYCLES = `SOFT_START_CYC
)(
  input wire logic pclk, // bus and timing clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic enable_in, // enable pin level
  input wire logic supply_lockout, // supply below lockout
  input wire logic thermal_shutdown, // over temperature
  input wire logic mode_level, // mode pin static level
  input wire logic mode_clock_present, // ext clock detected on mode pin
  input wire logic duty_extend, // max duty / duty extension state
  input wire logic soft_start_cap_done, // cap ramp done (high if pin open)
  input wire logic fb_below_uv, // feedback below 90 percent
  input wire logic fb_above_uv_rel, // feedback above 93 percent
  input wire logic fb_above_ov, // feedback above 110 percent
  input wire logic fb_below_ov_rel, // feedback below 107 percent
  input wire logic output_overvolt_guard, // output sense over threshold
  input wire logic switch_node_short, // 0.43 V drop comparator
  input wire logic overcurrent, // current limit comparator
  output logic power_ok_flag_oe, // pull-down enable of flag
  output logic power_ok_flag_o, // flag driven level (always low)
  output logic switching_en, // gate drive allowed
  output logic hs_pulse_end, // terminate high-side pulse
  output logic forced_pwm, // forced pwm selected
  output logic sync_locked, // following external clock
  output logic freq_reduce, // frequency fold-down active
  output logic sync_clock_output_sync, // clock out follows mode pin
  output logic [1:0] ilim_sel // current limit threshold code
);
  // RULE22: intervals counted in pclk cycles
  localparam int FILT_C = `FILTER_CYC;
  localparam int REL_C = `RELEASE_CYC;
  localparam int CW = 16;

  // refuse counts that the 16-bit timers cannot hold
  if (HICCUP_CYCLES < 1 || HICCUP_CYCLES >= (1 << CW) || SOFT_CYCLES < 1 ||
      SOFT_CYCLES >= (1 << CW) || FILT_C >= (1 << CW) || REL_C >= (1 << CW))
  begin : g_count_check
    $error("cycle counts out of range");
  end

  typedef struct packed {
    seq_state_t st;
    logic [CW-1:0] tmr;
    logic [CW-1:0] uv_cnt;
    logic [CW-1:0] ov_cnt;
    logic [CW-1:0] rel_cnt;
    logic undervolt_detect;
    logic overvolt_detect;
    logic latch_mode;
    logic [1:0] ilim;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic pg_oe;
    logic sw_en;
    logic hs_end;
    logic fpwm;
    logic lock;
    logic fred;
    logic cko_sync;
  } state_t;

  state_t cur_reg, cur_next;
  logic fault_event;

  // =====================================================
  // next state
  always_comb
  begin
    cur_next = cur_reg;
    cur_next.ready = 1'b0;
    cur_next.err = 1'b0;
    // apb slave, one wait state: answer in access phase's second cycle
    if (psel && penable && !cur_reg.ready)
    begin
      cur_next.ready = 1'b1;
      if (paddr == `REG_CTRL_ADDR)
      begin
        if (pwrite)
        begin
          cur_next.latch_mode = pwdata[`CTRL_LATCH_BIT];
          // RULE20: threshold choice
          if (pwdata[`CTRL_ILIM_LSB+1 -: 2] != 2'h3)
            cur_next.ilim = pwdata[`CTRL_ILIM_LSB+1 -: 2];
        end
        cur_next.rdata = {29'h0, cur_reg.ilim, cur_reg.latch_mode};
      end
      else if (paddr == `REG_STATUS_ADDR)
      begin
        cur_next.rdata = {24'h0, cur_reg.undervolt_detect, cur_reg.overvolt_detect,
          ~cur_reg.pg_oe, cur_reg.sw_en, 1'b0, cur_reg.st};
        cur_next.err = pwrite;
      end
      else
      begin
        cur_next.rdata = 32'h0;
        cur_next.err = 1'b1;
      end
    end
    // RULE10: uv filter, strictly more than 30 us
    if (fb_below_uv && cur_reg.st == ST_RUN)
    begin
      if (cur_reg.uv_cnt < CW'(FILT_C))
        cur_next.uv_cnt = cur_reg.uv_cnt + 1'b1;
      else
        cur_next.undervolt_detect = 1'b1;
    end
    else
      cur_next.uv_cnt = '0;
    if (fb_above_uv_rel)
      cur_next.undervolt_detect = 1'b0;
    // RULE14: ov filter
    if (fb_above_ov && cur_reg.st == ST_RUN)
    begin
      if (cur_reg.ov_cnt < CW'(FILT_C))
        cur_next.ov_cnt = cur_reg.ov_cnt + 1'b1;
      else
        cur_next.overvolt_detect = 1'b1;
    end
    else
      cur_next.ov_cnt = '0;
    // RULE15: ov release level
    if (fb_below_ov_rel)
      cur_next.overvolt_detect = 1'b0;
    // RULE12: fault escalation while undervolt
    if (fault_event)
    begin
      cur_next.tmr = '0;
      cur_next.st = cur_reg.latch_mode ? ST_LATCH : ST_HICCUP;
    end
    case (cur_reg.st)
      ST_OFF:
      begin
        // RULE21: soft-start from enable rise
        cur_next.tmr = '0;
        cur_next.st = ST_SOFT;
      end
      ST_SOFT:
      begin
        if (cur_reg.tmr < CW'(SOFT_CYCLES))
          cur_next.tmr = cur_reg.tmr + 1'b1;
        // RULE21: internal minimum and cap ramp both done
        else if (soft_start_cap_done)
        begin
          cur_next.st = ST_RUN;
          cur_next.rel_cnt = '0;
        end
      end
      ST_RUN:
      begin
      end
      ST_HICCUP:
      begin
        // RULE19: restart after delay
        if (cur_reg.tmr < CW'(HICCUP_CYCLES))
          cur_next.tmr = cur_reg.tmr + 1'b1;
        else
        begin
          cur_next.st = ST_SOFT;
          cur_next.tmr = '0;
          cur_next.undervolt_detect = 1'b0;
          cur_next.overvolt_detect = 1'b0;
        end
      end
      // RULE18: latch held until enable low or lockout (reset)
      default:
        cur_next.st = ST_LATCH;
    endcase
    // RULE11: release delay counter, restarts on any pulling condition
    if (cur_reg.st != ST_RUN || cur_next.undervolt_detect || cur_next.overvolt_detect ||
        thermal_shutdown)
      cur_next.rel_cnt = '0;
    else if (cur_reg.rel_cnt < CW'(REL_C))
      cur_next.rel_cnt = cur_reg.rel_cnt + 1'b1;
    // RULE8: pull flag low until released
    // RULE9: release once all clear
    cur_next.pg_oe = !(cur_reg.rel_cnt >= CW'(REL_C) && cur_next.rel_cnt >= CW'(REL_C));
    // RULE13: ov halts; RULE16: output guard halts
    cur_next.sw_en = (cur_next.st == ST_SOFT || cur_next.st == ST_RUN) && !thermal_shutdown &&
      !cur_next.overvolt_detect && !output_overvolt_guard;
    // RULE17: short drop comparator and RULE20: limit end the pulse
    cur_next.hs_end = overcurrent || switch_node_short;
    // RULE1: mode level; RULE2: sync forces pwm; RULE5: no wait on soft-start
    cur_next.fpwm = mode_level || mode_clock_present;
    // RULE6: duty extension drops the lock
    cur_next.lock = mode_clock_present && !duty_extend;
    // RULE7: frequency fold-down
    cur_next.fred = duty_extend;
    cur_next.cko_sync = mode_clock_present && !duty_extend;
    // RULE18: enable low or lockout clears the sequencer
    // ctrl and the bus answer survive, so software can set up before enable
    if (!enable_in || supply_lockout)
    begin
      cur_next.st = ST_OFF;
      cur_next.tmr = '0;
      cur_next.uv_cnt = '0;
      cur_next.ov_cnt = '0;
      cur_next.rel_cnt = '0;
      cur_next.undervolt_detect = 1'b0;
      cur_next.overvolt_detect = 1'b0;
      // RULE8: flag pulled in shutdown
      cur_next.pg_oe = 1'b1;
      cur_next.sw_en = 1'b0;
    end
  end

  // RULE12: fault while undervolt
  assign fault_event = cur_reg.st == ST_RUN && cur_reg.undervolt_detect &&
    (overcurrent || switch_node_short || output_overvolt_guard);

  // =====================================================
  // state register; the flag starts pulled low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_reg <= '0;
      cur_reg.pg_oe <= 1'b1;
    end
    else
      cur_reg <= cur_next;
  end

  assign prdata = cur_reg.rdata;
  assign pready = cur_reg.ready;
  assign pslverr = cur_reg.err;
  assign power_ok_flag_oe = cur_reg.pg_oe;
  assign power_ok_flag_o = 1'b0;
  assign switching_en = cur_reg.sw_en;
  assign hs_pulse_end = cur_reg.hs_end;
  assign forced_pwm = cur_reg.fpwm;
  assign sync_locked = cur_reg.lock;
  assign freq_reduce = cur_reg.fred;
  assign sync_clock_output_sync = cur_reg.cko_sync;
  assign ilim_sel = cur_reg.ilim;

  // =====================================================
  // checks: filters and release
  // outputs are registered, so most checks look one cycle after the cause
  // a filter flag may only rise if its comparator was high 300 cycles before
  // RULE10: undervolt needs the full filter
  a_uv_filter_min: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    $rose(cur_reg.undervolt_detect) |-> $past(fb_below_uv, 300)) else $error("uv too early");
  // RULE14: overvolt needs the full filter
  a_ov_filter_min: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    $rose(cur_reg.overvolt_detect) |-> $past(fb_above_ov, 300)) else $error("ov too early");
  // RULE11: release comparator clears undervolt
  a_uv_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    fb_above_uv_rel |=> !cur_reg.undervolt_detect) else $error("uv kept after release");
  // RULE15: release comparator clears overvolt
  a_ov_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    fb_below_ov_rel |=> !cur_reg.overvolt_detect) else $error("ov kept after release");
  // RULE11: release needs delay
  a_release_delay: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    $fell(power_ok_flag_oe) |-> cur_reg.rel_cnt >= CW'(REL_C)) else $error("early release");

  // =====================================================
  // checks: power ok flag
  // RULE8: flag low during soft-start
  a_flag_soft_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    cur_reg.st == ST_SOFT |-> power_ok_flag_oe) else $error("flag high in soft-start");
  // RULE8: flag low while uv or ov stands
  a_flag_uvov_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    cur_reg.undervolt_detect || cur_reg.overvolt_detect |-> power_ok_flag_oe)
    else $error("flag high during uv or ov");
  // RULE8: flag low in shutdown, lockout or over temperature
  a_flag_off_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    !enable_in || supply_lockout || thermal_shutdown |=> power_ok_flag_oe)
    else $error("flag high in shutdown");
  // RULE8: flag low in hiccup or latch
  a_flag_fault_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    cur_reg.st inside {ST_HICCUP, ST_LATCH} |-> power_ok_flag_oe)
    else $error("flag high in fault");
  // RULE9: flag released once the delay has run clear
  a_flag_release: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    $past(cur_reg.rel_cnt) >= CW'(REL_C) && cur_reg.rel_cnt >= CW'(REL_C) |-> !power_ok_flag_oe)
    else $error("flag held after release");

  // =====================================================
  // checks: switching
  // RULE13: overvolt stops switching
  a_ov_halts_sw: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    cur_reg.overvolt_detect |-> !switching_en) else $error("switching during ov");
  // RULE16: output guard stops switching
  a_guard_stops_sw: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    output_overvolt_guard |=> !switching_en) else $error("switching during guard");
  // RULE18 RULE19: no switching in hiccup or latch
  a_fault_sw_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE18 RULE19
    cur_reg.st inside {ST_HICCUP, ST_LATCH} |-> !switching_en) else $error("switching in fault");

  // =====================================================
  // checks: sequencer
  // RULE21: enable starts soft-start
  a_enable_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
    cur_reg.st == ST_OFF && enable_in && !supply_lockout |=> cur_reg.st == ST_SOFT)
    else $error("no soft-start after enable");
  // RULE21: internal minimum before run
  a_soft_min: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
    cur_reg.st == ST_SOFT && cur_reg.tmr < CW'(SOFT_CYCLES) |=> cur_reg.st != ST_RUN)
    else $error("soft-start too short");
  // RULE19: restart after the hiccup delay
  a_hiccup_restart: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
    cur_reg.st == ST_HICCUP && cur_reg.tmr >= CW'(HICCUP_CYCLES) && enable_in &&
    !supply_lockout |=> cur_reg.st == ST_SOFT) else $error("hiccup not restarted");
  // RULE18: latch holds
  a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    cur_reg.st == ST_LATCH && enable_in && !supply_lockout |=> cur_reg.st == ST_LATCH)
    else $error("latch left");
  // RULE12: fault escalates
  a_fault_escal: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    fault_event && enable_in && !supply_lockout |=> cur_reg.st inside {ST_HICCUP, ST_LATCH})
    else $error("fault not escalated");

  // =====================================================
  // checks: pulse end and mode
  // RULE17: short or limit ends the pulse
  a_pulse_end: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    overcurrent || switch_node_short |=> hs_pulse_end) else $error("pulse not ended");
  // RULE20: pulse runs on when no comparator trips
  a_pulse_free: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    !overcurrent && !switch_node_short |=> !hs_pulse_end)
    else $error("pulse ended without cause");
  // RULE20: threshold code stays legal
  a_ilim_legal: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    ilim_sel != 2'h3) else $error("illegal limit code");
  // RULE1: mode level picks pwm when no clock
  a_mode_level: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    !mode_clock_present |=> forced_pwm == $past(mode_level))
    else $error("mode level ignored");
  // RULE6: duty extension drops lock
  a_duty_unlock: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    duty_extend |=> !sync_locked && freq_reduce) else $error("lock kept in duty ext");
  // RULE7: no fold-down outside duty extension
  a_freq_follow: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    !duty_extend |=> !freq_reduce) else $error("fold-down without duty ext");
  // RULE2: sync clock forces pwm
  a_sync_fpwm: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    mode_clock_present |=> forced_pwm) else $error("sync without pwm");
  // RULE2: sync clock locks switching and clock out
  a_sync_lock: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    mode_clock_present && !duty_extend |=> sync_locked && sync_clock_output_sync)
    else $error("sync clock not followed");
endmodule
`default_nettype wire

// File: stage_model.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// feedback divider comparators and pulled-up flag line
module stage_model (
  input wire logic [7:0] fb_pct, // feedback, percent of target
  input wire logic flag_oe, // flag pull-down enable
  input wire logic flag_o, // flag driven level
  output logic below_uv, // under 90 percent
  output logic above_uv_rel, // over 93 percent
  output logic above_ov, // over 110 percent
  output logic below_ov_rel, // under 107 percent
  output logic flag_line // resolved flag level
);
  assign below_uv = fb_pct < 8'h5A;
  assign above_uv_rel = fb_pct > 8'h5D;
  assign above_ov = fb_pct > 8'h6E;
  assign below_ov_rel = fb_pct < 8'h6B;
  assign flag_line = flag_oe ? flag_o : 1'b1;
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import pg_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic en, lock, hot, mlev, mclk, dext, ssd, ovg, sns, oc;
  logic bu, aur, ao, bor, foe, fo, fl, sw, hse, fpwm, slk, frd, cks;
  logic [1:0] ilim;
  logic [7:0] fb;
  int mismatches, n_tests;
  // ====
  // design and far side
  power_good_fault_supervisor #(.HICCUP_CYCLES(50), .SOFT_CYCLES(20)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_in(en), .supply_lockout(lock),
    .thermal_shutdown(hot), .mode_level(mlev), .mode_clock_present(mclk),
    .duty_extend(dext), .soft_start_cap_done(ssd), .fb_below_uv(bu),
    .fb_above_uv_rel(aur), .fb_above_ov(ao), .fb_below_ov_rel(bor),
    .output_overvolt_guard(ovg), .switch_node_short(sns), .overcurrent(oc),
    .power_ok_flag_oe(foe), .power_ok_flag_o(fo), .switching_en(sw),
    .hs_pulse_end(hse), .forced_pwm(fpwm), .sync_locked(slk),
    .freq_reduce(frd), .sync_clock_output_sync(cks), .ilim_sel(ilim));
  stage_model i_stage (.fb_pct(fb), .flag_oe(foe), .flag_o(fo), .below_uv(bu),
    .above_uv_rel(aur), .above_ov(ao), .below_ov_rel(bor), .flag_line(fl));
  // ====
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++)
      @(posedge pclk);
    chk(s, v);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      chk(pready, 1'b1);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_reg;
    for (int c = 0; c < 3; c++)
    begin
      apb(1'b1, 12'h000, 32'(c) << 1);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'(c) << 1);
      chk(ilim, 32'(c));
    end
    apb(1'b1, 12'h000, 32'h6);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, 12'h008, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 12'h004, 32'hFF);
    chk(er, 1'b1);
  endtask
  task automatic t_start;
    en <= 1'b1;
    // flag stands for an in-range clock of wide pulses
    mclk <= 1'b1;
    cyc(15);
    chk(fl, 1'b0);
    chk({fpwm, slk}, 2'h3);
    mclk <= 1'b0;
    wait_for(fl, 1'b1, 1400);
    chk(sw, 1'b1);
  endtask
  task automatic t_mode;
    mlev <= 1'b1;
    cyc(3);
    chk(fpwm, 1'b1);
    mlev <= 1'b0;
    mclk <= 1'b1;
    cyc(3);
    chk({fpwm, slk, cks}, 3'h7);
    dext <= 1'b1;
    cyc(3);
    chk({slk, frd, cks}, 3'h2);
    mclk <= 1'b0;
    cyc(3);
    chk({fpwm, frd}, 2'h1);
    dext <= 1'b0;
  endtask
  task automatic t_hiccup;
    oc <= 1'b1;
    cyc(3);
    chk(hse, 1'b1);
    oc <= 1'b0;
    fb <= 8'h55;
    cyc(280);
    chk(fl, 1'b1);
    cyc(30);
    chk(fl, 1'b0);
    oc <= 1'b1;
    cyc(4);
    chk(sw, 1'b0);
    oc <= 1'b0;
    fb <= 8'h64;
    wait_for(sw, 1'b1, 150);
    wait_for(fl, 1'b1, 1400);
  endtask
  task automatic t_latch;
    apb(1'b1, 12'h000, 32'h5);
    fb <= 8'h55;
    cyc(310);
    sns <= 1'b1;
    cyc(4);
    sns <= 1'b0;
    fb <= 8'h64;
    cyc(200);
    chk(sw, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2:0], ST_LATCH);
    en <= 1'b0;
    cyc(3);
    chk(fl, 1'b0);
    en <= 1'b1;
    wait_for(fl, 1'b1, 1400);
  endtask
  task automatic t_ov;
    ovg <= 1'b1;
    cyc(3);
    chk(sw, 1'b0);
    ovg <= 1'b0;
    cyc(3);
    chk(sw, 1'b1);
    fb <= 8'h73;
    cyc(310);
    chk({fl, sw}, 2'h0);
    fb <= 8'h64;
    cyc(1100);
    chk(fl, 1'b0);
    wait_for(fl, 1'b1, 200);
    chk(sw, 1'b1);
    hot <= 1'b1;
    cyc(3);
    chk(fl, 1'b0);
    hot <= 1'b0;
    wait_for(fl, 1'b1, 1500);
  endtask
  // ====
  // clock, watchdog, main sequence
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    #3000000;
    mismatches++;
    give_verdict;
  end
  initial
  begin
    {psel, penable, pwrite, en, lock, hot, mlev, mclk, dext, ovg, sns, oc} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fb = 8'h64;
    ssd = 1'b1;
    presetn = 1'b0;
    cyc(3);
    chk(foe, 1'b1);
    presetn <= 1'b1;
    t_reg;
    t_start;
    t_mode;
    t_hiccup;
    t_latch;
    t_ov;
    give_verdict;
  end
endmodule
`default_nettype wire
